// ===== common/rmsc_map.vh
// Register map, field positions, reset values and timing constants of the mode select control
`ifndef RMSC_MAP_VH
`define RMSC_MAP_VH

// Register byte offsets
`define RMSC_ADDR_STATUS 8'h00
`define RMSC_ADDR_CLEAR 8'h04
`define RMSC_ADDR_ENABLE 8'h08
`define RMSC_ADDR_STATE 8'h0C
`define RMSC_ADDR_CONTROL 8'h10
`define RMSC_ADDR_EDGES 8'h14

// Event bits of status, clear and enable
`define RMSC_EV_W 4
`define RMSC_EV_IMPAIR 0
`define RMSC_EV_RECOVER 1
`define RMSC_EV_FREQ_CHG 2
`define RMSC_EV_REF_SWITCH 3

// Fields of the state register
`define RMSC_ST_MODE 0
`define RMSC_ST_REF 1
`define RMSC_ST_IMPAIR 2
`define RMSC_ST_FREERUN 3
`define RMSC_ST_FCFG_LO 4
`define RMSC_ST_FCFG_HI 5
`define RMSC_ST_FLIVE_LO 6
`define RMSC_ST_FLIVE_HI 7

// Fields and reset value of the control register, reset value of the enable register
`define RMSC_CTL_MON_EN 0
`define RMSC_CTL_RESET 1'h1
`define RMSC_EN_RESET 4'h0

// Frequency select codes, upper select first
`define RMSC_FSEL_19M44 2'h0
`define RMSC_FSEL_8K 2'h1
`define RMSC_FSEL_1M544 2'h2
`define RMSC_FSEL_2M048 2'h3

// Expected reference falling edges in one 125 us frame
`define RMSC_EXP_19M44 12'h97E
`define RMSC_EXP_8K 12'h001
`define RMSC_EXP_1M544 12'h0C1
`define RMSC_EXP_2M048 12'h100
`define RMSC_EDGE_TOL 2

// Timing: clock rate, frame period, pulse width, DS2 rate
`define RMSC_CLK_KHZ 250000
`define RMSC_FRAME_NS 125000
`define RMSC_PULSE_NS 122
`define RMSC_DS2_KHZ 6312
// Cycles after reset release before the pin synchronisers hold pin levels
`define RMSC_SYNC_FILL 2'h2

`endif

// ===== src/rmsc_sync.v
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module rmsc_sync #(
	parameter W = 1
) (
	input wire clk_sys,
	input wire rst_n,
	input wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] stage1;
	reg [W-1:0] stage2;

	// First stage feeds only the second stage; both clear low at reset
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			stage1 <= {W{1'b0}};
			stage2 <= {W{1'b0}};
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
		end
	end

	assign sync_out = stage2;
endmodule // rmsc_sync

// ===== src/rmsc_top.v
// Mode and reference select control with frame pulse, DS2 clock and impairment monitor
//
// Contract
// [R1] Normal or freerun chosen from op_state_select, captured at frame pulse rise.
// [R2] Captured ref_source_select low picks primary, high picks secondary reference.
// [R3] Undriven ref_source_select reads low, so primary is the default.
// [R4] Two frequency selects choose one of four reference rates for both inputs.
// [R5] Codes: 00 19.44 MHz, 01 8 kHz, 10 1.544 MHz, 11 2.048 MHz.
// [R6] Controller resets the device after any frequency select change.
// [R7] Impairment flag high while the monitor has forced freerun itself.
// [R8] DS2 clock output at 6.312 MHz from the common synthesized timing.
// [R9] Frame pulse active high about 122 ns, every 125 us, at frame start.
// [R10] Controller holds mode and reference selects stable around frame pulse rise.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "rmsc_map.vh"
module rmsc_top #(
	parameter FRAME_CYC = (`RMSC_FRAME_NS * (`RMSC_CLK_KHZ / 1000)) / 1000,
	parameter CNT_W = 15,
	parameter EDGE_W = 12,
	parameter EDGE_TOL = `RMSC_EDGE_TOL
) (
	input wire clk_sys,
	input wire rst_n,
	input wire op_state_select,
	input wire ref_source_select,
	input wire freq_select_lo,
	input wire freq_select_hi,
	input wire primary_ref_in,
	input wire secondary_ref_in,
	input wire [7:0] bus_addr,
	input wire [31:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	output reg [31:0] bus_rdata,
	output wire irq,
	output reg frame_pulse_8k,
	output reg ds2_clock_out,
	output reg impairment_freerun_flag,
	output reg freerun_active,
	output reg selected_ref_out
);
	// Pulse width rounded down to whole cycles, at least one
	localparam PULSE_RAW = (`RMSC_PULSE_NS * (`RMSC_CLK_KHZ / 1000)) / 1000;
	localparam PULSE_CYC = (PULSE_RAW < 1) ? 1 : PULSE_RAW;
	localparam [CNT_W-1:0] FRAME_LAST = FRAME_CYC[CNT_W-1:0] - 1'b1;
	localparam [CNT_W-1:0] PULSE_LAST = PULSE_CYC[CNT_W-1:0] - 1'b1;
	// Phase increment of the DS2 accumulator
	localparam [63:0] DS2_INC64 = (64'd`RMSC_DS2_KHZ << 32) / 64'd`RMSC_CLK_KHZ;
	localparam [31:0] DS2_INC = DS2_INC64[31:0];
	localparam [EDGE_W-1:0] EDGE_MAX = {EDGE_W{1'b1}};
	localparam [EDGE_W-1:0] TOL = EDGE_TOL[EDGE_W-1:0];

	// Expected falling edges per frame for a frequency code
	function [EDGE_W-1:0] rmsc_expect;
		input [1:0] code;
		begin
			case (code)
				`RMSC_FSEL_19M44: rmsc_expect = `RMSC_EXP_19M44;
				`RMSC_FSEL_8K: rmsc_expect = `RMSC_EXP_8K;
				`RMSC_FSEL_1M544: rmsc_expect = `RMSC_EXP_1M544;
				default: rmsc_expect = `RMSC_EXP_2M048;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	wire [5:0] pins_sync;
	wire mode_s;
	wire ref_source_select_s;
	wire [1:0] freq_live;
	wire pri_s;
	wire sec_s;

	rmsc_sync #(
		.W(6)
	) u_pin_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in({freq_select_hi, freq_select_lo, ref_source_select, op_state_select,
			secondary_ref_in, primary_ref_in}),
		.sync_out(pins_sync)
	);

	assign pri_s = pins_sync[0];
	assign sec_s = pins_sync[1];
	assign mode_s = pins_sync[2];
	assign ref_source_select_s = pins_sync[3];
	assign freq_live = pins_sync[5:4];

	////////////////////////////////////////////////////////////////////////////////
	// Frame timing and select capture

	reg [CNT_W-1:0] frm_cnt;
	reg mode_cap;
	reg ref_cap;
	reg ref_switched;
	wire frame_edge;

	// Last cycle of a frame: pulse rises and selects are gated in on this edge
	assign frame_edge = (frm_cnt == FRAME_LAST);

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			frm_cnt <= {CNT_W{1'b0}};
			frame_pulse_8k <= 1'b0;
			mode_cap <= 1'b0;
			ref_cap <= 1'b0; // see [R3]
			ref_switched <= 1'b0;
		end else begin
			ref_switched <= 1'b0;
			if (frame_edge) begin
				frm_cnt <= {CNT_W{1'b0}};
				frame_pulse_8k <= 1'b1; // see [R9]
				mode_cap <= mode_s; // see [R1]
				ref_cap <= ref_source_select_s; // see [R2]
				ref_switched <= (ref_source_select_s != ref_cap);
			end else begin
				frm_cnt <= frm_cnt + 1'b1;
				if (frm_cnt == PULSE_LAST)
					frame_pulse_8k <= 1'b0; // see [R9]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Frequency configuration, caught once the synchronisers refill after reset

	reg [1:0] freq_cfg;
	reg [1:0] cfg_wait;
	reg cfg_done;
	wire freq_chg;

	// The synchronisers clear during reset, so latching at once would catch zeros
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			freq_cfg <= `RMSC_FSEL_19M44;
			cfg_done <= 1'b0;
			cfg_wait <= 2'h0;
		end else if (!cfg_done) begin
			cfg_wait <= cfg_wait + 1'b1;
			if (cfg_wait == `RMSC_SYNC_FILL) begin
				freq_cfg <= freq_live; // see [R4] [R6]
				cfg_done <= 1'b1;
			end
		end
	end

	// Live selects differing from the latched setting call for a reset
	assign freq_chg = cfg_done && (freq_live != freq_cfg); // see [R6]

	////////////////////////////////////////////////////////////////////////////////
	// Reference mux and input impairment monitor

	reg ref_prev;
	reg [EDGE_W-1:0] edge_cnt;
	reg [EDGE_W-1:0] edge_last;
	reg impaired;
	reg mon_en;
	wire ref_sel;
	wire ref_fall;
	wire [EDGE_W-1:0] exp_cnt;
	wire [EDGE_W-1:0] dev;
	wire window_bad;

	assign ref_sel = ref_cap ? sec_s : pri_s; // see [R2]
	assign ref_fall = ref_prev & ~ref_sel;
	assign exp_cnt = rmsc_expect(freq_cfg); // see [R5]
	assign dev = (edge_cnt > exp_cnt) ? (edge_cnt - exp_cnt) : (exp_cnt - edge_cnt);
	assign window_bad = (dev > TOL);

	// Count falling edges per frame and judge each window at the frame edge
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			ref_prev <= 1'b0;
			edge_cnt <= {EDGE_W{1'b0}};
			edge_last <= {EDGE_W{1'b0}};
			impaired <= 1'b0;
		end else begin
			ref_prev <= ref_sel;
			if (frame_edge) begin
				edge_cnt <= {EDGE_W{1'b0}};
				edge_last <= edge_cnt;
				// ref_switched is low again by the next frame edge, so a window after a reference switch is judged too
				if (!mon_en)
					impaired <= 1'b0;
				else if (!ref_switched)
					impaired <= window_bad; // see [R7]
			end else if (ref_fall && edge_cnt != EDGE_MAX) begin
				edge_cnt <= edge_cnt + 1'b1;
			end
		end
	end

	// Mode outputs: monitor forces freerun on its own
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			impairment_freerun_flag <= 1'b0;
			freerun_active <= 1'b0;
			selected_ref_out <= 1'b0;
		end else begin
			impairment_freerun_flag <= impaired; // see [R7]
			freerun_active <= mode_cap | impaired; // see [R1] [R7]
			selected_ref_out <= ref_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// DS2 clock from a phase accumulator on the common clock

	reg [31:0] ds2_acc;

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			ds2_acc <= 32'h00000000;
			ds2_clock_out <= 1'b0;
		end else begin
			ds2_acc <= ds2_acc + DS2_INC; // see [R8]
			ds2_clock_out <= ds2_acc[31]; // see [R8]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Events, sticky status and interrupt

	reg [`RMSC_EV_W-1:0] status;
	reg [`RMSC_EV_W-1:0] irq_en;
	reg impaired_d;
	reg freq_chg_d;
	wire [`RMSC_EV_W-1:0] events;
	wire [`RMSC_EV_W-1:0] clr_mask;
	wire wr_clr;

	assign events[`RMSC_EV_IMPAIR] = impaired & ~impaired_d;
	assign events[`RMSC_EV_RECOVER] = ~impaired & impaired_d;
	assign events[`RMSC_EV_FREQ_CHG] = freq_chg & ~freq_chg_d;
	assign events[`RMSC_EV_REF_SWITCH] = ref_switched;
	assign wr_clr = bus_wr && (bus_addr == `RMSC_ADDR_CLEAR);
	assign clr_mask = wr_clr ? bus_wdata[`RMSC_EV_W-1:0] : {`RMSC_EV_W{1'b0}};

	// A new event wins over a clear in the same cycle
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			status <= {`RMSC_EV_W{1'b0}};
			impaired_d <= 1'b0;
			freq_chg_d <= 1'b0;
		end else begin
			status <= (status & ~clr_mask) | events;
			impaired_d <= impaired;
			freq_chg_d <= freq_chg;
		end
	end

	assign irq = |(status & irq_en);

	////////////////////////////////////////////////////////////////////////////////
	// Register port: writes in one cycle, read data the cycle after

	reg [31:0] next_rdata;

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			irq_en <= `RMSC_EN_RESET;
			mon_en <= `RMSC_CTL_RESET;
		end else if (bus_wr) begin
			if (bus_addr == `RMSC_ADDR_ENABLE)
				irq_en <= bus_wdata[`RMSC_EV_W-1:0];
			if (bus_addr == `RMSC_ADDR_CONTROL)
				mon_en <= bus_wdata[`RMSC_CTL_MON_EN];
		end
	end

	// Read mux; unmapped and write-only offsets read zero
	always @* begin
		next_rdata = 32'h00000000;
		case (bus_addr)
			`RMSC_ADDR_STATUS: next_rdata[`RMSC_EV_W-1:0] = status;
			`RMSC_ADDR_ENABLE: next_rdata[`RMSC_EV_W-1:0] = irq_en;
			`RMSC_ADDR_CONTROL: next_rdata[`RMSC_CTL_MON_EN] = mon_en;
			`RMSC_ADDR_EDGES: next_rdata[EDGE_W-1:0] = edge_last;
			`RMSC_ADDR_STATE: begin
				next_rdata[`RMSC_ST_MODE] = mode_cap;
				next_rdata[`RMSC_ST_REF] = ref_cap;
				next_rdata[`RMSC_ST_IMPAIR] = impaired;
				next_rdata[`RMSC_ST_FREERUN] = mode_cap | impaired;
				next_rdata[`RMSC_ST_FCFG_HI:`RMSC_ST_FCFG_LO] = freq_cfg;
				next_rdata[`RMSC_ST_FLIVE_HI:`RMSC_ST_FLIVE_LO] = freq_live;
			end
			default: next_rdata = 32'h00000000;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge clk_sys) begin
		if (!rst_n)
			bus_rdata <= 32'h00000000;
		else if (bus_rd)
			bus_rdata <= next_rdata;
		else
			bus_rdata <= 32'h00000000;
	end
endmodule // rmsc_top

// ===== testbench/rmsc_ctl_model.sv
// Model of the system control logic and the two reference sources
`timescale 1ns/100ps
module rmsc_ctl_model #(
	parameter int REF_PER = 200
) (
	input logic clk_sys,
	input logic rst_n,
	input logic frame_pulse_8k,
	input logic mode_req,
	input logic ref_req,
	input logic [1:0] fsel_req,
	output logic op_state_select = 1'h0,
	output logic ref_source_select = 1'h0,
	output logic freq_select_lo,
	output logic freq_select_hi,
	output logic primary_ref_in,
	output logic secondary_ref_in
);
	int cnt = 0;
	logic fp_d = 1'h0;
	////////////////////////////////
	// One valid code held; the bench resets after each change except the one in test_events
	assign {freq_select_hi, freq_select_lo} = fsel_req;
	// One primary and two secondary falls per period
	assign primary_ref_in = cnt < REF_PER / 2;
	assign secondary_ref_in = (cnt % (REF_PER / 2)) < REF_PER / 4;
	// Selects move as the pulse ends, far from its rising edge
	always @(posedge clk_sys) begin
		fp_d <= frame_pulse_8k;
		cnt <= (!rst_n || cnt == REF_PER - 1) ? 0 : cnt + 1;
		if (!rst_n) begin
			op_state_select <= 1'h0;
			ref_source_select <= 1'h0;
		end else if (fp_d && !frame_pulse_8k) begin
			op_state_select <= mode_req;
			ref_source_select <= ref_req;
		end
	end
endmodule // rmsc_ctl_model

// ===== testbench/rmsc_top_props.sv
// Checker of frame pulse, select timing, DS2 clock and read port
`timescale 1ns/100ps
module rmsc_props #(
	parameter int FRAME_CYC = 200
) (
	input logic clk_sys,
	input logic rst_n,
	input logic bus_rd,
	input logic [31:0] bus_rdata,
	input logic frame_pulse_8k,
	input logic ds2_clock_out,
	input logic impairment_freerun_flag,
	input logic freerun_active
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	int since;
	logic seen;
	////////////////////////////////
	// Cycles since the last pulse rise, so a long frame needs no long delay
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			since <= 0;
			seen <= 1'b0;
		end else if ($rose(frame_pulse_8k)) begin
			since <= 1;
			seen <= 1'b1;
		end else begin
			since <= since + 1;
		end
	end
	// Steady runs of the pulse and of each DS2 half period
	sequence fp_hi; frame_pulse_8k throughout ##29 1; endsequence
	sequence ds2_hi; ds2_clock_out throughout ##18 1; endsequence
	sequence ds2_lo; !ds2_clock_out throughout ##18 1; endsequence
	pulse_width_a: assert property ($rose(frame_pulse_8k) |-> fp_hi ##1 !frame_pulse_8k)
		else $error("frame pulse width wrong");
	frame_period_a: assert property ($rose(frame_pulse_8k) && seen |-> since == FRAME_CYC)
		else $error("frame period wrong");
	mode_hold_a: assert property (!$rose(frame_pulse_8k) |=> $stable(freerun_active))
		else $error("freerun changed off a frame edge");
	flag_hold_a: assert property (!$rose(frame_pulse_8k) |=> $stable(impairment_freerun_flag))
		else $error("impairment flag changed off a frame edge");
	flag_freerun_a: assert property (impairment_freerun_flag |-> freerun_active)
		else $error("impairment flag without freerun");
	read_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
		else $error("read data outside its cycle");
	ds2_high_a: assert property ($rose(ds2_clock_out) |-> ds2_hi ##[1:2] !ds2_clock_out)
		else $error("DS2 high time wrong");
	ds2_low_a: assert property ($fell(ds2_clock_out) |-> ds2_lo ##[1:2] ds2_clock_out)
		else $error("DS2 low time wrong");
endmodule // rmsc_props
bind rmsc_top rmsc_props #(.FRAME_CYC(FRAME_CYC)) rmsc_props_inst (.clk_sys(clk_sys),
	.rst_n(rst_n), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .frame_pulse_8k(frame_pulse_8k),
	.ds2_clock_out(ds2_clock_out), .impairment_freerun_flag(impairment_freerun_flag),
	.freerun_active(freerun_active));

// ===== testbench/rmsc_top_tb.sv
// Testbench of the mode and reference select control
`timescale 1ns/100ps
`include "rmsc_map.vh"
module rmsc_top_tb;
	localparam int FC = 200;
	logic clk_sys = 0, rst_n = 0, bus_wr = 0, bus_rd = 0, mode_req = 0, ref_req = 0;
	logic [1:0] fsel_req = 2'h1;
	logic [7:0] bus_addr = 8'h00;
	logic [31:0] bus_wdata = 32'h0, bus_rdata, got;
	wire op_state_select, ref_source_select, freq_select_lo, freq_select_hi, irq;
	wire primary_ref_in, secondary_ref_in, frame_pulse_8k, ds2_clock_out;
	wire impairment_freerun_flag, freerun_active, selected_ref_out;
	int fails = 0, n_tests = 0, cyc = 0, n, m, h;
	rmsc_top #(.FRAME_CYC(FC)) rmsc_top_inst (.clk_sys, .rst_n, .op_state_select,
		.ref_source_select, .freq_select_lo, .freq_select_hi, .primary_ref_in, .secondary_ref_in,
		.bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .irq, .frame_pulse_8k,
		.ds2_clock_out, .impairment_freerun_flag, .freerun_active, .selected_ref_out);
	rmsc_ctl_model #(.REF_PER(FC)) rmsc_ctl_model_inst (.clk_sys, .rst_n, .frame_pulse_8k,
		.mode_req, .ref_req, .fsel_req, .op_state_select, .ref_source_select, .freq_select_lo,
		.freq_select_hi, .primary_ref_in, .secondary_ref_in);
	////////////////////////////////
	initial forever #2 clk_sys = ~clk_sys;
	// Cut a hung run short
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish();
		end
	end
	task tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus_wr <= 1'h1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk_sys);
		bus_wr <= 1'h0;
	endtask
	// Read data are taken in the one cycle after the strobe
	task rd(input logic [7:0] a);
		@(posedge clk_sys);
		bus_rd <= 1'h1;
		bus_addr <= a;
		@(posedge clk_sys);
		bus_rd <= 1'h0;
		#1 got = bus_rdata;
	endtask
	task do_reset();
		@(posedge clk_sys);
		rst_n <= 1'h0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'h1;
	endtask
	// Wait for the next rising edge of the frame pulse
	task frame();
		for (int i = 0; i < 500 && frame_pulse_8k !== 1'h0; i++) @(posedge clk_sys) #1;
		for (int i = 0; i < 500 && frame_pulse_8k !== 1'h1; i++) @(posedge clk_sys) #1;
	endtask
	// Count reference falls, DS2 rises and pulse-high cycles
	task count(input int len);
		logic ps, pd;
		n = 0;
		m = 0;
		h = 0;
		for (int i = 0; i < len; i++) begin
			ps = selected_ref_out;
			pd = ds2_clock_out;
			h += frame_pulse_8k === 1'h1;
			@(posedge clk_sys) #1;
			n += ps === 1'h1 && selected_ref_out === 1'h0;
			m += pd === 1'h0 && ds2_clock_out === 1'h1;
		end
	endtask
	task test_regs();
		rd(`RMSC_ADDR_CONTROL);
		chk("control", 32'h1, got);
		rd(8'hFC);
		chk("unmapped", 32'h0, got);
		wr(`RMSC_ADDR_ENABLE, 32'hF);
		rd(`RMSC_ADDR_ENABLE);
		chk("enable", 32'hF, got);
		wr(`RMSC_ADDR_ENABLE, 32'h0);
		$display("test_regs done");
	endtask
	task test_pulse();
		frame();
		count(FC);
		chk("pulse width", 30, h);
		chk("next pulse", 1'h1, frame_pulse_8k);
		$display("test_pulse done");
	endtask
	// A mode change waits for the frame edge
	task test_mode();
		frame();
		mode_req <= 1'h1;
		repeat (100) @(posedge clk_sys);
		#1 chk("early freerun", 1'h0, freerun_active);
		frame();
		repeat (2) @(posedge clk_sys);
		#1 chk("freerun", 1'h1, freerun_active);
		mode_req <= 1'h0;
		frame();
		frame();
		repeat (2) @(posedge clk_sys);
		#1 chk("normal", 1'h0, freerun_active);
		$display("test_mode done");
	endtask
	task test_ref();
		count(2 * FC);
		chk("primary falls", 2, n);
		chk("ds2 rises", 1'h1, m >= 10 && m <= 11);
		ref_req <= 1'h1;
		frame();
		frame();
		count(2 * FC);
		chk("secondary falls", 4, n);
		rd(`RMSC_ADDR_STATE);
		chk("state ref", 1'h1, got[`RMSC_ST_REF]);
		ref_req <= 1'h0;
		frame();
		frame();
		$display("test_ref done");
	endtask
	// Sticky switch and select-change events, their clear, the last edge count
	task test_events();
		rd(`RMSC_ADDR_STATUS);
		chk("status switch", 32'h8, got);
		rd(`RMSC_ADDR_EDGES);
		chk("edges", 32'h1, got);
		fsel_req <= 2'h3;
		repeat (4) @(posedge clk_sys);
		rd(`RMSC_ADDR_STATE);
		chk("state live", 32'h3, got[7:6]);
		rd(`RMSC_ADDR_STATUS);
		chk("status freq", 32'hC, got);
		wr(`RMSC_ADDR_CLEAR, 32'hC);
		rd(`RMSC_ADDR_STATUS);
		chk("status clear", 32'h0, got);
		$display("test_events done");
	endtask
	// Every code latched; all but 8 kHz see one fall per frame, far below their expected count
	task test_freq();
		for (int c = 0; c < 4; c++) begin
			fsel_req <= c[1:0];
			do_reset();
			wr(`RMSC_ADDR_ENABLE, 32'h1);
			frame();
			frame();
			frame();
			rd(`RMSC_ADDR_STATE);
			chk("freq code", {c[1:0], c[1:0]}, got[7:4]);
			chk("impair flag", c != 1, impairment_freerun_flag);
			chk("irq", c != 1, irq);
			wr(`RMSC_ADDR_ENABLE, 32'h0);
			#1 chk("irq masked", 1'h0, irq);
			wr(`RMSC_ADDR_CLEAR, 32'h1);
			wr(`RMSC_ADDR_ENABLE, 32'h1);
			#1 chk("irq cleared", 1'h0, irq);
			// Monitor off: forced freerun ends at the next frame edge
			if (c == 0) begin
				wr(`RMSC_ADDR_CONTROL, 32'h0);
				rd(`RMSC_ADDR_CONTROL);
				chk("control off", 32'h0, got);
				frame();
				rd(`RMSC_ADDR_STATUS);
				chk("status recover", 32'h2, got);
				chk("flag cleared", 1'h0, impairment_freerun_flag);
				chk("freerun cleared", 1'h0, freerun_active);
			end
		end
		fsel_req <= 2'h1;
		do_reset();
		$display("test_freq done");
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'h1;
		test_regs();
		test_pulse();
		test_mode();
		test_ref();
		test_events();
		test_freq();
		tally_and_finish();
	end
endmodule // rmsc_top_tb
